// >>> src/cocd_top.sv
// Module: decodes stored configuration and applies it to the clock outputs
// Notes on behaviour
// - Aux pin source: 01 ref, 10 synth, 11 lock
// - Lock cfg 0: push-pull, high when unlocked
// - Lock cfg 1: open drain, low when unlocked
// - Lock cfg ignored when aux carries clock
// - Keep bit 0: synth clock held low on both pins while unlocked; ref clock on aux not gated
// - Keep bit 1: outputs toggle while unlocked
// - Format bit picks 20.12 or 12.20
// - Four stored ratios, indexed one used
// - Codes 000/001/010 gate synth/aux/both
// - Code 011: pin enables ratio shift
// - Code 111: pin forces aux to synth
// - Bandwidth 1 Hz doubling to 128 Hz
// - Gating pin high disables outputs
// - Set-select pins choose stored set
// - Shift enabled: right shift 1 to 4
// - Override only while pin high
// Pin and clock inputs reach the outputs three edges later:
// two synchroniser stages, then the output register.

`timescale 1ns/1ps
`default_nettype none
module cocd_top (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	// Stored per-set configuration
	input  wire logic [31:0] USER_RATIO0_I,
	input  wire logic [31:0] USER_RATIO1_I,
	input  wire logic [31:0] USER_RATIO2_I,
	input  wire logic [31:0] USER_RATIO3_I,
	input  wire logic [7:0]  AUX_SOURCE_SELECT_I,
	input  wire logic [7:0]  RATIO_SHIFT_SELECT_I,
	// Stored global configuration
	input  wire logic        LOCK_INDICATOR_DRIVE_CFG_I,
	input  wire logic        KEEP_CLOCK_ON_UNLOCK_I,
	input  wire logic        RATIO_FORMAT_SELECT_I,
	input  wire logic [2:0]  SPECIAL_PIN_FUNCTION_I,
	input  wire logic [2:0]  MIN_LOOP_BANDWIDTH_I,
	// Board pins
	input  wire logic [1:0]  SET_SELECT_I,
	input  wire logic        SPECIAL_FUNCTION_PIN_I,
	// Clock sources and lock state
	input  wire logic        REF_CLK_I,
	input  wire logic        SYN_CLK_I,
	input  wire logic        PLL_LOCKED_I,
	// Clock outputs
	output logic             SYN_CLK_O,
	output logic             SYN_CLK_OE_O,
	output logic             AUX_O,
	output logic             AUX_OE_O,
	// Ratio to synthesizer
	output logic      [31:0] EFFECTIVE_RATIO_O,
	output logic      [4:0]  RATIO_FRAC_BITS_O,
	output logic             RATIO_FORMAT_O,
	output logic      [7:0]  MIN_BANDWIDTH_HZ_O,
	output logic      [1:0]  ACTIVE_SET_O
);
	import cocd_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		// Synchronisers; only the second stage feeds logic
		logic [1:0]  set_m;
		logic [1:0]  set_s;
		logic        pin_m;
		logic        pin_s;
		logic        ref_m;
		logic        ref_s;
		logic        syn_m;
		logic        syn_s;
		logic        lock_m;
		logic        lock_s;

		// Registered pin drivers
		logic        syn_clk;
		logic        syn_oe;
		logic        aux;
		logic        aux_oe;

		// Registered ratio and loop settings
		logic [31:0] ratio;
		logic [4:0]  frac_bits;
		logic        fmt;
		logic [7:0]  bw_hz;
		logic [1:0]  set;
	} cocd_state_s;

	cocd_state_s st;
	cocd_state_s next_st;

	// ==========================================
	// Stored sets as arrays
	logic [31:0] ratio_mem [NUM_SETS];
	logic [1:0]  src_mem   [NUM_SETS];
	logic [1:0]  shift_mem [NUM_SETS];

	// One entry per stored set; set n uses ratio n
	// and bits 2n+1:2n of each packed per-set field
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SETS; gi++) begin : g_set
			assign src_mem[gi]   = AUX_SOURCE_SELECT_I[2*gi +: 2];
			assign shift_mem[gi] = RATIO_SHIFT_SELECT_I[2*gi +: 2];
			if (gi == 0) begin : g_ratio0
				assign ratio_mem[gi] = USER_RATIO0_I;
			end else if (gi == 1) begin : g_ratio1
				assign ratio_mem[gi] = USER_RATIO1_I;
			end else if (gi == 2) begin : g_ratio2
				assign ratio_mem[gi] = USER_RATIO2_I;
			end else begin : g_ratio3
				assign ratio_mem[gi] = USER_RATIO3_I;
			end
		end
	endgenerate

	// ==========================================
	// Unlock gating of the synthesized clock, on whichever pin carries it
	// Clocks are oversampled by CLK_I, so the copies on the pins
	// lag their sources and move in steps of one CLK_I period
	logic clocks_run;
	logic syn_gated;

	assign clocks_run = st.lock_s | KEEP_CLOCK_ON_UNLOCK_I;
	assign syn_gated  = clocks_run & st.syn_s;

	// ==========================================
	// Unlock indicator driver
	logic lock_val;
	logic lock_oe;

	always_comb begin
		if (LOCK_INDICATOR_DRIVE_CFG_I) begin
			// Open drain: pull low while unlocked, float while locked
			lock_val = 1'b0;
			lock_oe  = ~st.lock_s;
		end else begin
			// Push-pull, high while unlocked
			lock_val = ~st.lock_s;
			lock_oe  = 1'b1;
		end
	end

	// ==========================================
	// Pin decode (synchronised values only)
	// The set pins are synchronised bit by bit; when the board changes
	// both at once a mixed index can stand for one cycle
	logic        gate_syn;
	logic        gate_aux;
	logic        shift_en;
	logic [1:0]  eff_src;
	logic [31:0] shifted_ratio;

	always_comb begin
		gate_syn = 1'b0;
		gate_aux = 1'b0;
		shift_en = 1'b0;
		eff_src  = src_mem[st.set_s];
		case (SPECIAL_PIN_FUNCTION_I)
			SPF_GATE_SYN: begin
				gate_syn = st.pin_s;
			end
			SPF_GATE_AUX: begin
				gate_aux = st.pin_s;
			end
			SPF_GATE_BOTH: begin
				gate_syn = st.pin_s;
				gate_aux = st.pin_s;
			end
			SPF_SHIFT_EN: begin
				shift_en = st.pin_s;
			end
			SPF_AUX_FORCE: begin
				if (st.pin_s) begin
					eff_src = AUX_SRC_SYN_CLK;
				end
			end
			default: begin
				// Reserved codes give the pin no function
				gate_syn = 1'b0;
				gate_aux = 1'b0;
				shift_en = 1'b0;
			end
		endcase
	end

	// The modifier acts only while the mode pin enables it
	cocd_ratio_shift u_shift (
		.ratio_i  (ratio_mem[st.set_s]),
		.enable_i (shift_en),
		.select_i (shift_mem[st.set_s]),
		.ratio_o  (shifted_ratio)
	);

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;
		// Two-stage synchronisers for pins and foreign clocks
		next_st.set_m  = SET_SELECT_I;
		next_st.set_s  = st.set_m;
		next_st.pin_m  = SPECIAL_FUNCTION_PIN_I;
		next_st.pin_s  = st.pin_m;
		next_st.ref_m  = REF_CLK_I;
		next_st.ref_s  = st.ref_m;
		next_st.syn_m  = SYN_CLK_I;
		next_st.syn_s  = st.syn_m;
		next_st.lock_m = PLL_LOCKED_I;
		next_st.lock_s = st.lock_m;

		// Synthesized clock pin; disabled means released
		next_st.syn_clk = syn_gated;
		next_st.syn_oe  = ~gate_syn;

		// Auxiliary pin
		next_st.aux    = 1'b0;
		next_st.aux_oe = ~gate_aux;
		case (eff_src)
			AUX_SRC_REF_CLK: begin
				next_st.aux = st.ref_s;
			end
			AUX_SRC_SYN_CLK: begin
				next_st.aux = syn_gated;
			end
			AUX_SRC_LOCK: begin
				// Gating wins over the indicator's own enable
				next_st.aux    = lock_val;
				next_st.aux_oe = ~gate_aux & lock_oe;
			end
			default: begin
				// Reserved source: pin driven low, enable unchanged
				next_st.aux = 1'b0;
			end
		endcase

		// Ratio and format
		// Shift happens in this cycle, so the modifier adds no latency
		next_st.ratio     = shifted_ratio;
		next_st.fmt       = RATIO_FORMAT_SELECT_I;
		case (RATIO_FORMAT_SELECT_I)
			FMT_12_20: begin
				next_st.frac_bits = FRAC_W_HA;
			end
			default: begin
				next_st.frac_bits = FRAC_W_HM;
			end
		endcase
		// One hertz at code 0, doubling per step
		next_st.bw_hz     = BW_BASE_HZ << MIN_LOOP_BANDWIDTH_I;
		next_st.set       = st.set_s;
	end

	// ==========================================
	// Registers
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			// Every field spelled out so the released state of each pin is visible
			st <= '{
				set_m:     2'h0,
				set_s:     2'h0,
				pin_m:     1'h0,
				pin_s:     1'h0,
				ref_m:     1'h0,
				ref_s:     1'h0,
				syn_m:     1'h0,
				syn_s:     1'h0,
				lock_m:    1'h0,
				lock_s:    1'h0,
				syn_clk:   1'h0,
				syn_oe:    1'h0,
				aux:       1'h0,
				aux_oe:    1'h0,
				ratio:     RATIO_RESET,
				frac_bits: FRAC_W_HM,
				fmt:       FMT_20_12,
				bw_hz:     BW_BASE_HZ,
				set:       2'h0
			};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	// Enables are high while the pin is driven; low means released
	assign SYN_CLK_O          = st.syn_clk;
	assign SYN_CLK_OE_O       = st.syn_oe;
	assign AUX_O              = st.aux;
	assign AUX_OE_O           = st.aux_oe;
	assign EFFECTIVE_RATIO_O  = st.ratio;
	assign RATIO_FRAC_BITS_O  = st.frac_bits;
	assign RATIO_FORMAT_O     = st.fmt;
	assign MIN_BANDWIDTH_HZ_O = st.bw_hz;
	assign ACTIVE_SET_O       = st.set;

endmodule : cocd_top
`default_nettype wire

// >>> include/cocd_pkg.sv
// Package: constants and types for the clock output configuration decoder
package cocd_pkg;

	// ==========================================
	// Auxiliary source codes
	localparam logic [1:0] AUX_SRC_RESERVED = 2'h0;
	localparam logic [1:0] AUX_SRC_REF_CLK  = 2'h1;
	localparam logic [1:0] AUX_SRC_SYN_CLK  = 2'h2;
	localparam logic [1:0] AUX_SRC_LOCK     = 2'h3;

	// ==========================================
	// Special pin function codes
	localparam logic [2:0] SPF_GATE_SYN   = 3'h0;
	localparam logic [2:0] SPF_GATE_AUX   = 3'h1;
	localparam logic [2:0] SPF_GATE_BOTH  = 3'h2;
	localparam logic [2:0] SPF_SHIFT_EN   = 3'h3;
	localparam logic [2:0] SPF_AUX_FORCE  = 3'h7;

	// ==========================================
	// Ratio formats and widths
	localparam int         RATIO_W        = 32;
	localparam int         NUM_SETS       = 4;
	localparam logic       FMT_20_12      = 1'b0;
	localparam logic       FMT_12_20      = 1'b1;
	localparam int         FRAC_BITS_HM   = 12;
	localparam int         FRAC_BITS_HA   = 20;
	localparam logic [4:0] FRAC_W_HM      = 5'h0c;
	localparam logic [4:0] FRAC_W_HA      = 5'h14;

	// ==========================================
	// Bandwidth: 1 Hz at code 0, doubling per step
	localparam logic [7:0] BW_BASE_HZ     = 8'h01;

	// ==========================================
	// Reset values
	localparam logic [31:0] RATIO_RESET   = 32'h0;
	localparam logic [1:0]  SRC_RESET     = AUX_SRC_RESERVED;

endpackage : cocd_pkg

// >>> src/cocd_ratio_shift.sv
// Module: applies the optional right shift of the ratio modifier
`timescale 1ns/1ps
`default_nettype none
module cocd_ratio_shift (
	// Ratio in and out
	input  wire logic [31:0] ratio_i,
	input  wire logic        enable_i,
	input  wire logic [1:0]  select_i,
	output logic      [31:0] ratio_o
);
	import cocd_pkg::*;

	// ==========================================
	// Shift by select+1 positions
	always_comb begin
		if (enable_i) begin
			ratio_o = ratio_i >> ({3'h0, select_i} + 5'h01);
		end else begin
			ratio_o = ratio_i;
		end
	end
endmodule : cocd_ratio_shift
`default_nettype wire

// >>> tb/cocd_checker.sv
// Checker: timing relations at the ports of the configuration decoder
`timescale 1ns/1ps
`default_nettype none
module cocd_checker (
	// Inputs of the decoder, and its ACTIVE_SET_O output
	input wire logic        CLK_I, RESET_I, SPECIAL_FUNCTION_PIN_I, PLL_LOCKED_I, SYN_CLK_I,
	input wire logic        LOCK_INDICATOR_DRIVE_CFG_I, KEEP_CLOCK_ON_UNLOCK_I,
	input wire logic [31:0] USER_RATIO0_I, USER_RATIO1_I, USER_RATIO2_I, USER_RATIO3_I,
	input wire logic [7:0]  AUX_SOURCE_SELECT_I, RATIO_SHIFT_SELECT_I,
	input wire logic [2:0]  SPECIAL_PIN_FUNCTION_I, MIN_LOOP_BANDWIDTH_I,
	input wire logic [1:0]  SET_SELECT_I, ACTIVE_SET_O,
	// Outputs of the decoder
	input wire logic        SYN_CLK_O, SYN_CLK_OE_O, AUX_O, AUX_OE_O,
	input wire logic [31:0] EFFECTIVE_RATIO_O,
	input wire logic [7:0]  MIN_BANDWIDTH_HZ_O
);
	logic [1:0]  s1, s2, src, sh;
	logic [2:0]  age;
	logic [31:0] rat;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// ==========================================
	// Mirror of the set synchroniser; age hides the pipeline fill after reset
	always_ff @(posedge CLK_I) begin
		s1 <= SET_SELECT_I;
		s2 <= s1;
		age <= RESET_I ? 3'h0 : age + {2'h0, age != 3'h5};
	end
	assign rat = s2[1] ? (s2[0] ? USER_RATIO3_I : USER_RATIO2_I) : (s2[0] ? USER_RATIO1_I : USER_RATIO0_I);
	assign src = AUX_SOURCE_SELECT_I[2 * s2 +: 2];
	assign sh  = RATIO_SHIFT_SELECT_I[2 * s2 +: 2];
	// ==========================================
	// Properties
	AST_BW: assert property (age == 3'h5 |-> MIN_BANDWIDTH_HZ_O == 8'h01 << $past(MIN_LOOP_BANDWIDTH_I))
		else $error("bandwidth code not decoded");
	AST_SET: assert property (age == 3'h5 |-> ACTIVE_SET_O == $past(SET_SELECT_I, 3))
		else $error("active set does not follow set pins");
	AST_UNLOCK_LOW: assert property (age == 3'h5 && !$past(PLL_LOCKED_I, 3) && !$past(KEEP_CLOCK_ON_UNLOCK_I) |-> !SYN_CLK_O)
		else $error("clock output not low while unlocked");
	AST_GATE_SYN: assert property (age == 3'h5 && $past(SPECIAL_FUNCTION_PIN_I, 3) && $past(SPECIAL_PIN_FUNCTION_I) inside {3'h0, 3'h2} |-> !SYN_CLK_OE_O)
		else $error("clock pin not disabled");
	AST_GATE_AUX: assert property (age == 3'h5 && $past(SPECIAL_FUNCTION_PIN_I, 3) && $past(SPECIAL_PIN_FUNCTION_I) inside {3'h1, 3'h2} |-> !AUX_OE_O)
		else $error("aux pin not disabled");
	AST_PIN_LOW: assert property ($fell(SPECIAL_FUNCTION_PIN_I) |-> ##3 SYN_CLK_OE_O)
		else $error("clock pin not enabled with mode pin low");
	AST_LOCK_PP: assert property (age == 3'h5 && !$past(SPECIAL_FUNCTION_PIN_I, 3) && $past(src) == 2'h3 && !$past(LOCK_INDICATOR_DRIVE_CFG_I) |-> AUX_OE_O && AUX_O == !$past(PLL_LOCKED_I, 3))
		else $error("push-pull unlock indicator wrong");
	AST_FORCE: assert property (age == 3'h5 && $past(PLL_LOCKED_I, 3) && $past(SPECIAL_FUNCTION_PIN_I, 3) && $past(SPECIAL_PIN_FUNCTION_I) == 3'h7 |-> AUX_O == $past(SYN_CLK_I, 3))
		else $error("aux override to synthesized clock failed");
	AST_RATIO: assert property (age == 3'h5 |-> EFFECTIVE_RATIO_O == ($past(SPECIAL_PIN_FUNCTION_I) == 3'h3 && $past(SPECIAL_FUNCTION_PIN_I, 3) ? $past(rat) >> ($past(sh) + 1) : $past(rat)))
		else $error("effective ratio wrong");
endmodule : cocd_checker
bind cocd_top cocd_checker cocd_checker_inst (.*);
`default_nettype wire

// >>> tb/cocd_board.sv
// Board model: drives the mode pins and the reference clock
`timescale 1ns/1ps
`default_nettype none
module cocd_board (
	// Clock and commands
	input  wire logic       clk_i,
	input  wire logic [1:0] set_cmd_i,
	input  wire logic       pin_cmd_i,
	// Pins toward the device
	output logic      [1:0] set_o,
	output logic            pin_o,
	output logic            ref_o
);
	int div = 0;
	initial begin
		set_o = 2'h0;
		pin_o = 1'b0;
		ref_o = 1'b0;
	end
	// Board logic changes pins between device edges
	always @(negedge clk_i) begin
		set_o <= set_cmd_i;
		pin_o <= pin_cmd_i;
		div <= (div + 1) % 3;
		if (div == 2)
			ref_o <= ~ref_o;
	end
endmodule : cocd_board
`default_nettype wire

// >>> tb/tb.sv
// Testbench: random configurations against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cocd_pkg::*;
	typedef struct {bit [31:0] rat [4]; int aux, sh, cfg, keep, fmt, spf, bw, set, pin, rc, sc, lk;} cocd_in_s;
	logic CLK_I, RESET_I, cfg, keep, fmt, syn_in, lk, pin_cmd, pin_w, ref_w, syn_o, syn_oe, aux_o, aux_oe, fmt_o;
	logic [31:0] r0, r1, r2, r3, eff;
	logic [7:0] aux, sh, bwhz;
	logic [4:0] frac;
	logic [2:0] spf, bw;
	logic [1:0] set_cmd, set_w, act;
	int failures = 0, checks_done = 0, i, n = 0;
	cocd_in_s hist [$];
	cocd_top cocd_top_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .USER_RATIO0_I(r0), .USER_RATIO1_I(r1),
		.USER_RATIO2_I(r2), .USER_RATIO3_I(r3), .AUX_SOURCE_SELECT_I(aux), .RATIO_SHIFT_SELECT_I(sh),
		.LOCK_INDICATOR_DRIVE_CFG_I(cfg), .KEEP_CLOCK_ON_UNLOCK_I(keep), .RATIO_FORMAT_SELECT_I(fmt),
		.SPECIAL_PIN_FUNCTION_I(spf), .MIN_LOOP_BANDWIDTH_I(bw), .SET_SELECT_I(set_w),
		.SPECIAL_FUNCTION_PIN_I(pin_w), .REF_CLK_I(ref_w), .SYN_CLK_I(syn_in), .PLL_LOCKED_I(lk),
		.SYN_CLK_O(syn_o), .SYN_CLK_OE_O(syn_oe), .AUX_O(aux_o), .AUX_OE_O(aux_oe), .EFFECTIVE_RATIO_O(eff),
		.RATIO_FRAC_BITS_O(frac), .RATIO_FORMAT_O(fmt_o), .MIN_BANDWIDTH_HZ_O(bwhz), .ACTIVE_SET_O(act));
	cocd_board cocd_board_inst (.clk_i(CLK_I), .set_cmd_i(set_cmd), .pin_cmd_i(pin_cmd), .set_o(set_w),
		.pin_o(pin_w), .ref_o(ref_w));
	initial begin
		CLK_I = 1'b0;
		forever #2.5 CLK_I = ~CLK_I;
	end
	// Inputs as the device sampled them, newest first
	always @(posedge CLK_I) begin
		hist.push_front('{'{r0, r1, r2, r3}, aux, sh, cfg, keep, fmt, spf, bw, set_w, pin_w, ref_w, syn_in, lk});
		if (hist.size() > 3)
			void'(hist.pop_back());
		n++;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Values that stand while reset is held
	task automatic chk_reset();
		chk("rst_ratio", RATIO_RESET, eff);
		chk("rst_frac", FRAC_BITS_HM, frac);
		chk("rst_bw", BW_BASE_HZ, bwhz);
		chk("rst_syn", 32'h0, syn_o);
		chk("rst_syn_oe", 32'h0, syn_oe);
		chk("rst_aux_oe", 32'h0, aux_oe);
	endtask : chk_reset
	// ==========================================
	// Model: pins two edges back, configuration from the last edge
	task automatic check_all();
		cocd_in_s c, p;
		int s, src, ul, eoe, ea;
		logic [31:0] r;
		c = hist[0];
		p = hist[2];
		s = p.set;
		src = (c.aux >> (2 * s)) % 4;
		if (c.spf == 7 && p.pin)
			src = 2;
		ul = !p.lk && !c.keep;
		r = c.rat[s];
		if (c.spf == 3 && p.pin)
			r = r >> ((c.sh >> (2 * s)) % 4 + 1);
		eoe = !(p.pin && c.spf inside {1, 2}) && !(src == 3 && c.cfg && p.lk);
		ea = src == 1 ? p.rc : (src == 2 ? p.sc && !ul : (src == 3 && !c.cfg && !p.lk));
		chk("ratio", r, eff);
		chk("set", s, act);
		chk("frac", c.fmt ? 20 : 12, frac);
		chk("fmt", c.fmt, fmt_o);
		chk("bw", 1 << c.bw, bwhz);
		chk("syn_oe", !(p.pin && c.spf inside {0, 2}), syn_oe);
		chk("aux_oe", eoe, aux_oe);
		if (!(p.pin && c.spf inside {0, 2}))
			chk("syn", ul ? 0 : p.sc, syn_o);
		if (eoe && !(src == 1 && ul))
			chk("aux", ea, aux_o);
	endtask : check_all
	task automatic tally_and_finish();
		$display("checks_done %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#200us;
		failures++;
		tally_and_finish();
	end
	initial begin
		i = $urandom(32'h19c7);
		{RESET_I, cfg, keep, fmt, syn_in, lk, pin_cmd, spf, bw, set_cmd, aux, sh} = 31'h40000000;
		{r0, r1, r2, r3} = 128'h0;
		repeat (8) @(posedge CLK_I);
		@(negedge CLK_I);
		chk_reset();
		RESET_I <= 1'b0;
		n = 0;
		for (i = 0; i < 24; i++) begin
			// A second reset in mid-run, with random settings still applied
			if (i == 12) begin
				RESET_I <= 1'b1;
				repeat (2) @(negedge CLK_I);
				chk_reset();
				RESET_I <= 1'b0;
				n = 0;
			end
			@(negedge CLK_I);
			r0 <= {12'($urandom), 20'h0};
			{r1, r2, r3} <= {$urandom, $urandom, $urandom};
			{aux, sh, bw, cfg, keep, fmt} <= 22'($urandom);
			spf <= 3'(i);
			repeat (60) begin
				@(negedge CLK_I);
				if (n > 5)
					check_all();
				syn_in <= ~syn_in;
				if ($urandom % 8 == 0)
					set_cmd <= 2'($urandom);
				if ($urandom % 4 == 0)
					pin_cmd <= ~pin_cmd;
				if ($urandom % 10 == 0)
					lk <= ~lk;
			end
		end
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
